//--- src/dtc_cc_unit.sv
// Sixteen-channel capture/compare array on two time bases, APB slave.
// Assumes pins and count inputs are synchronous to pclk.
`timescale 1ns/1ps

module dtc_cc_unit #(
  parameter int NCH = 16,
  parameter int TW = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [NCH-1:0] cc_pin_in, // Channel pin levels
  output logic [NCH-1:0] cc_pin_out, // Channel pin drive
  output logic [NCH-1:0] cc_pin_oe, // Channel pin enable
  output logic [NCH-1:0] cc_req, // Channel requests
  input wire logic ext_count_in, // External count input
  input wire logic feeder_ovf_in // Feeder timer overflow pulse
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic stag_reg;
  logic [2:0] stag_cnt_reg;
  logic slot;
  logic [3:0] tctrl_reg [2];
  logic [TW-1:0] rel_reg [2];
  logic [TW-1:0] cnt [2];
  logic [1:0] tovf;
  logic [1:0] tupd;
  logic [1:0] tload;
  logic [TW-1:0] val_reg [NCH];
  logic [5:0] mode_reg [NCH];
  logic [NCH-1:0] done_reg;
  logic [NCH-1:0] hit_reg;
  logic [NCH-1:0] pin_prev_reg;
  logic [NCH-1:0] match;
  logic [NCH-1:0] cap_ev;
  logic [NCH-1:0] pair_ev;
  logic [NCH-1:0] req_clr;
  logic acc;
  logic wr_fire;
  logic hit;
  logic [31:0] rdata_next;
  logic [3:0] idx;

  assign acc = psel & penable;
  assign wr_fire = acc & pready & pwrite;
  assign idx = paddr[5:2];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------

  // Read decode and address check
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == dtc_pkg::ADDR_GCTRL) begin
      rdata_next[dtc_pkg::GCTRL_STAG_BIT] = stag_reg;
    end else if (paddr == dtc_pkg::ADDR_T0CTRL) begin
      rdata_next[3:0] = tctrl_reg[0];
    end else if (paddr == dtc_pkg::ADDR_T1CTRL) begin
      rdata_next[3:0] = tctrl_reg[1];
    end else if (paddr == dtc_pkg::ADDR_T0VAL) begin
      rdata_next[TW-1:0] = cnt[0];
    end else if (paddr == dtc_pkg::ADDR_T1VAL) begin
      rdata_next[TW-1:0] = cnt[1];
    end else if (paddr == dtc_pkg::ADDR_T0REL) begin
      rdata_next[TW-1:0] = rel_reg[0];
    end else if (paddr == dtc_pkg::ADDR_T1REL) begin
      rdata_next[TW-1:0] = rel_reg[1];
    end else if (paddr == dtc_pkg::ADDR_REQ) begin
      rdata_next[NCH-1:0] = cc_req;
    end else if (paddr[7:6] == dtc_pkg::PAGE_CCVAL
                 && 32'(idx) < NCH) begin
      rdata_next[TW-1:0] = val_reg[idx];
    end else if (paddr[7:6] == dtc_pkg::PAGE_CCMODE
                 && 32'(idx) < NCH) begin
      rdata_next[5:0] = mode_reg[idx];
    end else begin
      hit = 1'b0;
    end
  end

  // One wait state, then answer with data or error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~hit;
      if (acc && !pready && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------
  // Global control and staggered slots
  // ----------------------------------------

  // Staggered mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stag_reg <= 1'b0;
    end else if (wr_fire && paddr == dtc_pkg::ADDR_GCTRL) begin
      stag_reg <= pwdata[dtc_pkg::GCTRL_STAG_BIT];
    end
  end

  // Slot counter: one slot in eight cycles when staggered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stag_cnt_reg <= 3'h0;
    end else if (stag_cnt_reg == dtc_pkg::STAG_LAST) begin
      stag_cnt_reg <= 3'h0;
    end else begin
      stag_cnt_reg <= stag_cnt_reg + 3'h1;
    end
  end

  assign slot = ~stag_reg | (stag_cnt_reg == 3'h0);

  // ----------------------------------------
  // Time bases
  // ----------------------------------------

  // Timer control and reload registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctrl_reg[0] <= dtc_pkg::TCTRL_RST;
      tctrl_reg[1] <= dtc_pkg::TCTRL_RST;
      rel_reg[0] <= dtc_pkg::REL_RST;
      rel_reg[1] <= dtc_pkg::REL_RST;
    end else if (wr_fire) begin
      if (paddr == dtc_pkg::ADDR_T0CTRL) begin
        tctrl_reg[0] <= pwdata[3:0];
      end else if (paddr == dtc_pkg::ADDR_T1CTRL) begin
        tctrl_reg[1] <= pwdata[3:0];
      end else if (paddr == dtc_pkg::ADDR_T0REL) begin
        rel_reg[0] <= pwdata[TW-1:0];
      end else if (paddr == dtc_pkg::ADDR_T1REL) begin
        rel_reg[1] <= pwdata[TW-1:0];
      end
    end
  end

  assign tload[0] = wr_fire & (paddr == dtc_pkg::ADDR_T0VAL);
  assign tload[1] = wr_fire & (paddr == dtc_pkg::ADDR_T1VAL);

  // Two independent timers, only the first takes external counts
  genvar t;
  generate
    for (t = 0; t < 2; t++) begin : g_tb
      dtc_timebase #(
        .EXT_OK(t == 0),
        .W(TW)
      ) u_tb (
        .pclk(pclk),
        .presetn(presetn),
        .src_sel(tctrl_reg[t][2:0]),
        .run(tctrl_reg[t][dtc_pkg::TCTRL_RUN_BIT]),
        .slot(slot),
        .feeder_ovf(feeder_ovf_in),
        .ext_in(ext_count_in),
        .load_en(tload[t]),
        .load_val(pwdata[TW-1:0]),
        .reload(rel_reg[t]),
        .count(cnt[t]),
        .ovf(tovf[t]),
        .upd(tupd[t])
      );
    end
  endgenerate

  // ----------------------------------------
  // Channel array
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic [2:0] md;
      logic tsel;
      logic dbl;
      logic se;
      logic is_cap;
      logic is_cmp;
      logic one_per;
      logic rise;
      logic fall;
      logic wr_val;
      logic wr_mode;
      logic ev;
      logic [TW-1:0] tval;

      assign md = mode_reg[i][2:0];
      assign tsel = mode_reg[i][dtc_pkg::MODE_TSEL_BIT];
      assign dbl = mode_reg[i][dtc_pkg::MODE_DBL_BIT];
      assign se = mode_reg[i][dtc_pkg::MODE_SE_BIT];
      assign is_cmp = md[2];
      assign is_cap = ~md[2] & (md != dtc_pkg::MD_OFF);
      assign one_per = (md == dtc_pkg::MD_CMP2)
                       | (md == dtc_pkg::MD_CMP3);
      assign tval = tsel ? cnt[1] : cnt[0];
      assign rise = cc_pin_in[i] & ~pin_prev_reg[i];
      assign fall = ~cc_pin_in[i] & pin_prev_reg[i];
      assign wr_val = wr_fire & (paddr[7:6] == dtc_pkg::PAGE_CCVAL)
                      & (32'(idx) == i);
      assign wr_mode = wr_fire & (paddr[7:6] == dtc_pkg::PAGE_CCMODE)
                       & (32'(idx) == i);

      // Edge selection for capture
      assign cap_ev[i] = is_cap & ~done_reg[i]
        & (((md == dtc_pkg::MD_CAP_RISE) & rise)
        | ((md == dtc_pkg::MD_CAP_FALL) & fall)
        | ((md == dtc_pkg::MD_CAP_BOTH) & (rise | fall)));

      // Match when the assigned timer takes a new value
      assign match[i] = is_cmp & ~done_reg[i] & tupd[tsel]
        & (tval == val_reg[i])
        & ~(one_per & hit_reg[i]);

      // Lower half toggles on partner matches in double mode
      if (i < NCH / 2) begin : g_pair
        assign pair_ev[i] = dbl & match[i + NCH / 2];
      end else begin : g_nopair
        assign pair_ev[i] = 1'b0;
      end

      assign ev = cap_ev[i] | match[i];

      // Pin history for edge detection
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_prev_reg[i] <= 1'b0;
        end else begin
          pin_prev_reg[i] <= cc_pin_in[i];
        end
      end

      // Channel value: capture wins over a software write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_reg[i] <= '0;
        end else if (cap_ev[i]) begin
          val_reg[i] <= tval;
        end else if (wr_val) begin
          val_reg[i] <= pwdata[TW-1:0];
        end
      end

      // Channel mode
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg[i] <= dtc_pkg::MODE_RST;
        end else if (wr_mode) begin
          mode_reg[i] <= pwdata[5:0];
        end
      end

      // Single event latch, rearmed by a mode write
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          done_reg[i] <= 1'b0;
        end else if ((ev | pair_ev[i]) && se) begin
          done_reg[i] <= 1'b1;
        end else if (wr_mode) begin
          done_reg[i] <= 1'b0;
        end
      end

      // One event per period in compare modes two and three, period restarts on overflow
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hit_reg[i] <= 1'b0;
        end else if (match[i]) begin
          hit_reg[i] <= 1'b1;
        end else if (tovf[tsel] || wr_mode) begin
          hit_reg[i] <= 1'b0;
        end
      end

      // Pin drive per compare mode; modes zero and two leave it unless double mode is set
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cc_pin_out[i] <= 1'b0;
        end else if ((match[i] & (dbl | (md == dtc_pkg::MD_CMP1)))
                     | (pair_ev[i] & ~done_reg[i])) begin
          cc_pin_out[i] <= ~cc_pin_out[i];
        end else if (match[i] && md == dtc_pkg::MD_CMP3) begin
          cc_pin_out[i] <= 1'b1;
        end else if (tovf[tsel] && md == dtc_pkg::MD_CMP3) begin
          cc_pin_out[i] <= 1'b0;
        end
      end

      // Pin is an output only for pin-driving compare modes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cc_pin_oe[i] <= 1'b0;
        end else begin
          cc_pin_oe[i] <= is_cmp & (dbl | (md == dtc_pkg::MD_CMP1)
                          | (md == dtc_pkg::MD_CMP3));
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Channel requests
  // ----------------------------------------
  assign req_clr = (wr_fire && paddr == dtc_pkg::ADDR_REQ)
                   ? pwdata[NCH-1:0] : '0;

  // Sticky requests, write one to clear, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_req <= '0;
    end else begin
      cc_req <= (cc_req & ~req_clr) | cap_ev | match
                | pair_ev;
    end
  end

endmodule

//--- src/dtc_pkg.sv
// Constants shared by the dual time base capture/compare unit.
// Assumes a 32-bit APB slave with byte addresses of 8 bits.
package dtc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_GCTRL = 8'h00;
  localparam logic [7:0] ADDR_T0CTRL = 8'h04;
  localparam logic [7:0] ADDR_T1CTRL = 8'h08;
  localparam logic [7:0] ADDR_T0VAL = 8'h0C;
  localparam logic [7:0] ADDR_T1VAL = 8'h10;
  localparam logic [7:0] ADDR_T0REL = 8'h14;
  localparam logic [7:0] ADDR_T1REL = 8'h18;
  localparam logic [7:0] ADDR_REQ = 8'h1C;
  localparam logic [1:0] PAGE_CCVAL = 2'h1;
  localparam logic [1:0] PAGE_CCMODE = 2'h2;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GCTRL_STAG_BIT = 0;
  localparam int TCTRL_RUN_BIT = 3;
  localparam int MODE_TSEL_BIT = 3;
  localparam int MODE_SE_BIT = 4;
  localparam int MODE_DBL_BIT = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] TCTRL_RST = 4'h0;
  localparam logic [15:0] REL_RST = 16'h0000;
  localparam logic [5:0] MODE_RST = 6'h00;

  // ----------------------------------------
  // Channel modes and count sources
  // ----------------------------------------
  localparam logic [2:0] MD_OFF = 3'h0;
  localparam logic [2:0] MD_CAP_RISE = 3'h1;
  localparam logic [2:0] MD_CAP_FALL = 3'h2;
  localparam logic [2:0] MD_CAP_BOTH = 3'h3;
  localparam logic [2:0] MD_CMP0 = 3'h4;
  localparam logic [2:0] MD_CMP1 = 3'h5;
  localparam logic [2:0] MD_CMP2 = 3'h6;
  localparam logic [2:0] MD_CMP3 = 3'h7;
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV4 = 3'h1;
  localparam logic [2:0] SRC_DIV16 = 3'h2;
  localparam logic [2:0] SRC_DIV64 = 3'h3;
  localparam logic [2:0] SRC_FEEDER = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;

  // Last slot counter value in staggered mode, eight cycles per slot
  localparam logic [2:0] STAG_LAST = 3'h7;

endpackage

//--- src/dtc_timebase.sv
// One reloadable up-counting time base with its count source select.
// Assumes all inputs are synchronous to pclk.
`timescale 1ns/1ps
module dtc_timebase #(
  parameter bit EXT_OK = 1'b0,
  parameter int W = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic [2:0] src_sel, // Count source
  input wire logic run, // Counting enabled
  input wire logic slot, // Staggered slot strobe
  input wire logic feeder_ovf, // Feeder timer overflow pulse
  input wire logic ext_in, // External count level
  input wire logic load_en, // Software load strobe
  input wire logic [W-1:0] load_val, // Software load value
  input wire logic [W-1:0] reload, // Reload value
  output logic [W-1:0] count, // Timer value
  output logic ovf, // Overflow pulse
  output logic upd // Value changed last edge
);

  logic [5:0] pre_reg;
  logic ext_prev_reg;
  logic src_tick;
  logic tick;

  // Prescaler advances once per slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 6'h00;
    end else if (slot) begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  // External count edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_in;
    end
  end

  // Count source select
  always_comb begin
    case (src_sel)
      dtc_pkg::SRC_DIV1: src_tick = slot;
      dtc_pkg::SRC_DIV4: src_tick = slot & (pre_reg[1:0] == 2'h0);
      dtc_pkg::SRC_DIV16: src_tick = slot & (pre_reg[3:0] == 4'h0);
      dtc_pkg::SRC_DIV64: src_tick = slot & (pre_reg == 6'h00);
      dtc_pkg::SRC_FEEDER: src_tick = feeder_ovf;
      dtc_pkg::SRC_EXT: src_tick = EXT_OK & ext_in & ~ext_prev_reg;
      default: src_tick = 1'b0;
    endcase
  end

  assign tick = run & src_tick;

  // Counter with reload on overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      ovf <= 1'b0;
      upd <= 1'b0;
    end else begin
      ovf <= tick & (&count) & ~load_en;
      upd <= tick | load_en;
      if (load_en) begin
        count <= load_val;
      end else if (tick) begin
        if (&count) begin
          count <= reload;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

//--- verification/dtc_cc_chk.sv
// Bus and request checks on the ports of the capture/compare unit.
// Assumes one pclk domain with presetn active low.
`timescale 1ns/1ps
module dtc_cc_chk #(
  parameter int NCH = 16
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [NCH-1:0] cc_pin_out, // Pin drive
  input wire logic [NCH-1:0] cc_pin_oe, // Pin enable
  input wire logic [NCH-1:0] cc_req // Requests
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus answer timing
  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero_data: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0) else $error("refused read returned data");
  a_err_map: assert property (pready |-> pslverr ==
    !((paddr < 8'h20 && paddr[1:0] == 2'b00) ||
    (paddr >= 8'h40 && paddr < 8'hC0)))
    else $error("pslverr does not match the address map");
  // Requests stay until software clears them
  a_req_sticky: assert property (|($past(cc_req) & ~cc_req) |->
    $past(pready && pwrite && paddr == dtc_pkg::ADDR_REQ))
    else $error("request dropped without a clear");
  // Pin direction follows the channel mode only
  a_oe_mode_write: assert property ($changed(cc_pin_oe) |->
    $past(pready && pwrite && paddr[7:6] == dtc_pkg::PAGE_CCMODE, 2))
    else $error("pin enable changed without a mode write");

  c_request: cover property (|cc_req);
  c_refused: cover property (pslverr);
  c_pin_high: cover property (|cc_pin_out);
endmodule

bind dtc_cc_unit dtc_cc_chk #(.NCH(NCH)) dtc_cc_chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_req(cc_req));

//--- verification/dtc_pin_model.sv
// Pin-side model for the channel pins of the capture/compare unit.
// Assumes the bench commands the external levels of undriven pins.
`timescale 1ns/1ps
module dtc_pin_model (
  input wire logic [15:0] cmd, // Levels asked by the bench
  input wire logic [15:0] pin_out, // Design drive level
  input wire logic [15:0] pin_oe, // Design drive enable
  output logic [15:0] lvl // Resolved pin level
);
  // Driven pins show the design, the others the external source
  assign lvl = (pin_oe & pin_out) | (~pin_oe & cmd);
endmodule

//--- verification/tb_dual_timebase_capture_compare.sv
// Self-checking bench for the dual time base capture/compare unit.
// Assumes the pin model and checker are compiled before it.
`timescale 1ns/1ps
module tb_dual_timebase_capture_compare;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext = 1'b0;
  logic fdr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] lfsr = 32'hE51A1D1A;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic last_err = 1'b0;
  logic [15:0] cmd = 16'h0;
  logic [15:0] pin_in, pin_out, pin_oe, req;
  logic [31:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;

  // ----------------------------------------
  // Clock, design and pin model
  // ----------------------------------------
  always #12.5 pclk = ~pclk;

  dtc_cc_unit dtc_cc_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cc_pin_in(pin_in), .cc_pin_out(pin_out), .cc_pin_oe(pin_oe),
    .cc_req(req), .ext_count_in(ext), .feeder_ovf_in(fdr));
  dtc_pin_model dtc_pin_model_i (.cmd(cmd), .pin_out(pin_out),
    .pin_oe(pin_oe), .lvl(pin_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [7:0] ca(input logic [1:0] pg, input int c);
    return {pg, 4'(c), 2'b00};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer, entered just after a rising edge; one idle edge
  // follows so that psel is never set twice in one time step
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  // Clears requests, loads timer 0, then compares pins and requests
  task automatic step(input logic [15:0] t, input logic [15:0] eo,
                      input logic [15:0] er);
    wr(dtc_pkg::ADDR_REQ, 32'hFFFF);
    wr(dtc_pkg::ADDR_T0VAL, {16'h0, t});
    cyc(3);
    @(negedge pclk);
    check({16'h0, pin_out & 16'h00A5}, {16'h0, eo});
    check({16'h0, req & 16'h01E4}, {16'h0, er});
    check({16'h0, pin_oe}, 32'h00A1);
    @(posedge pclk);
  endtask

  // Compares each read answer with the oldest expected value
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && pwrite === 1'b0 && exp_q.size() > 0) begin
      check(prdata, exp_q.pop_front());
    end
  end

  task automatic stop_test();
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #200000;
    failures++;
    stop_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] tv[4];
    logic [15:0] a;
    logic [2:0] n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(dtc_pkg::ADDR_T0CTRL, 32'h0);
    rd(dtc_pkg::ADDR_T1REL, 32'h0);
    check({31'h0, last_err}, 32'h0);
    rd(8'hC4, 32'h0);
    check({31'h0, last_err}, 32'h1);
    // Every mode register reads its reset zero, every value register reads back its write
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      rd(ca(dtc_pkg::PAGE_CCMODE, c), 32'h0);
      wr(ca(dtc_pkg::PAGE_CCVAL, c), r);
      rd(ca(dtc_pkg::PAGE_CCVAL, c), {16'h0, r[15:0]});
    end
    // Feeder overflows and external edges as count sources
    r = rnd();
    n = r[2:0];
    wr(dtc_pkg::ADDR_T0CTRL, 32'h8 | 32'(dtc_pkg::SRC_EXT));
    wr(dtc_pkg::ADDR_T1CTRL, 32'h8 | 32'(dtc_pkg::SRC_FEEDER));
    repeat (n) begin
      fdr <= 1'b1;
      ext <= 1'b1;
      @(posedge pclk);
      fdr <= 1'b0;
      ext <= 1'b0;
      @(posedge pclk);
    end
    wr(dtc_pkg::ADDR_T0CTRL, 32'h0);
    wr(dtc_pkg::ADDR_T1CTRL, 32'h0);
    rd(dtc_pkg::ADDR_T0VAL, {29'h0, n});
    rd(dtc_pkg::ADDR_T1VAL, {29'h0, n});
    // Staggered slots, then the divide-by-four prescaler, 64 edges each
    wr(dtc_pkg::ADDR_GCTRL, 32'h1);
    wr(dtc_pkg::ADDR_T1CTRL, 32'h8 | 32'(dtc_pkg::SRC_DIV1));
    cyc(60);
    wr(dtc_pkg::ADDR_T1CTRL, 32'h0);
    wr(dtc_pkg::ADDR_GCTRL, 32'h0);
    rd(dtc_pkg::ADDR_T1VAL, {29'h0, n} + 32'h8);
    wr(dtc_pkg::ADDR_T1CTRL, 32'h8 | 32'(dtc_pkg::SRC_DIV4));
    cyc(60);
    wr(dtc_pkg::ADDR_T1CTRL, 32'h0);
    rd(dtc_pkg::ADDR_T1VAL, {29'h0, n} + 32'h18);
    // Capture on rise, fall, both, and both on the second timer
    wr(ca(dtc_pkg::PAGE_CCMODE, 10), 32'h01);
    wr(ca(dtc_pkg::PAGE_CCMODE, 11), 32'h02);
    wr(ca(dtc_pkg::PAGE_CCMODE, 12), 32'h03);
    wr(ca(dtc_pkg::PAGE_CCMODE, 13), 32'h0B);
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      tv[k] = r[15:0];
    end
    for (int k = 0; k < 2; k++) begin
      wr(dtc_pkg::ADDR_T0VAL, {16'h0, tv[2*k]});
      wr(dtc_pkg::ADDR_T1VAL, {16'h0, tv[2*k+1]});
      cmd <= (k == 0) ? 16'h3C00 : 16'h0000;
      cyc(3);
    end
    rd(ca(dtc_pkg::PAGE_CCVAL, 10), {16'h0, tv[0]});
    rd(ca(dtc_pkg::PAGE_CCVAL, 11), {16'h0, tv[2]});
    rd(ca(dtc_pkg::PAGE_CCVAL, 12), {16'h0, tv[2]});
    rd(ca(dtc_pkg::PAGE_CCVAL, 13), {16'h0, tv[3]});
    rd(dtc_pkg::ADDR_REQ, 32'h3C00);
    // Compare channels on timer 0, never reached from the reload value
    r = rnd();
    a = 16'h4000 | {3'h0, r[12:0]};
    wr(ca(dtc_pkg::PAGE_CCVAL, 8), {16'h0, a ^ 16'h8000});
    for (int c = 0; c < 8; c++) begin
      wr(ca(dtc_pkg::PAGE_CCVAL, c), {16'h0, a});
    end
    wr(ca(dtc_pkg::PAGE_CCMODE, 0), 32'h25);
    wr(ca(dtc_pkg::PAGE_CCMODE, 8), 32'h04);
    wr(ca(dtc_pkg::PAGE_CCMODE, 5), 32'h15);
    wr(ca(dtc_pkg::PAGE_CCMODE, 6), 32'h06);
    wr(ca(dtc_pkg::PAGE_CCMODE, 7), 32'h07);
    wr(ca(dtc_pkg::PAGE_CCMODE, 2), 32'h04);
    step(a, 16'h00A1, 16'h00E4);
    step(a ^ 16'h8000, 16'h00A0, 16'h0100);
    step(a, 16'h00A1, 16'h0004);
    // Overflow reloads and ends the period
    wr(dtc_pkg::ADDR_T0REL, 32'h0010);
    step(16'hFFFC, 16'h00A1, 16'h0000);
    wr(dtc_pkg::ADDR_T0CTRL, 32'h8);
    cyc(4);
    wr(dtc_pkg::ADDR_T0CTRL, 32'h0);
    @(negedge pclk);
    check({16'h0, pin_out & 16'h00A5}, 32'h0021);
    @(posedge pclk);
    step(a, 16'h00A0, 16'h00C4);
    stop_test();
  end
endmodule
